// ### design/mhs_pkg.sv
`include "mhs_regs.svh"

package mhs_pkg;

    // Address channel payload.
    typedef struct packed {
        logic [`MHS_ADDR_W-1:0] addr;
        logic [2:0]             prot;
    } mhs_addr_type;

    // Write data channel payload.
    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  strb;
    } mhs_wdata_type;

    // Read data channel payload.
    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  resp;
    } mhs_rdata_type;

    // State of the write path.
    typedef struct packed {
        logic          awready;
        logic          wready;
        logic          aw_have;
        logic          w_have;
        logic          bvalid;
        logic [1:0]    bresp;
        mhs_addr_type  aw;
        mhs_wdata_type w;
    } mhs_wstate_type;

    // State of the read path.
    typedef struct packed {
        logic          arready;
        logic          rvalid;
        mhs_rdata_type r;
    } mhs_rstate_type;

    // Configuration and violation state.
    typedef struct packed {
        logic enable;
        logic seen;
        logic pulse;
    } mhs_cfg_type;

endpackage

// ### design/mhs_regs.sv
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`include "mhs_regs.svh"

module mhs_regs
    import mhs_pkg::*;
#(
    parameter logic [11:0] PART_NUM  = 12'h5A6,  // Arbitrary value.
    parameter logic [6:0]  DESIGNER  = 7'h2A,    // Arbitrary value.
    parameter logic [3:0]  CONT_CODE = 4'h7,     // Arbitrary value.
    parameter logic [3:0]  REVISION  = 4'h1,     // Arbitrary value.
    parameter logic [31:0] COMP_ID   = 32'hC3A51E69 // Arbitrary value, byte n is component byte n.
) (
    // Clock and reset.
    input  wire logic           clk,
    input  wire logic           rst,

    // AXI4-Lite write address channel.
    input  wire logic           s_axi_awvalid,
    output      logic           s_axi_awready,
    input  wire mhs_addr_type   s_axi_aw,

    // AXI4-Lite write data channel.
    input  wire logic           s_axi_wvalid,
    output      logic           s_axi_wready,
    input  wire mhs_wdata_type  s_axi_w,

    // AXI4-Lite write response channel.
    output      logic           s_axi_bvalid,
    input  wire logic           s_axi_bready,
    output      logic [1:0]     s_axi_bresp,

    // AXI4-Lite read address channel.
    input  wire logic           s_axi_arvalid,
    output      logic           s_axi_arready,
    input  wire mhs_addr_type   s_axi_ar,

    // AXI4-Lite read data channel.
    output      logic           s_axi_rvalid,
    input  wire logic           s_axi_rready,
    output      mhs_rdata_type  s_axi_r,

    // Link to the secure doorbell status register.
    output      logic           violation_set,
    output      logic           violation_irq_enable
);

    ////////////////////////////////////////////////////////////////////////////////

    mhs_wstate_type w_q;
    mhs_wstate_type next_w;
    mhs_rstate_type r_q;
    mhs_rstate_type next_r;
    mhs_cfg_type    c_q;
    mhs_cfg_type    next_c;
    logic           wr_fire;
    logic           wr_viol;
    logic           rd_viol;

    // Tells whether a byte address falls on the given register word.
    function automatic logic is_at(input logic [`MHS_ADDR_W-1:0] addr,
                                   input logic [`MHS_ADDR_W-1:0] off);
        is_at = ({addr[`MHS_ADDR_W-1:2], 2'h0} == off);
    endfunction

    // Builds the read answer for one address.
    function automatic mhs_rdata_type read_word(input mhs_addr_type a,
                                                input mhs_cfg_type  c);
        mhs_rdata_type res;
        res.data = 32'h0;
        res.resp = `MHS_RESP_OKAY;
        if (is_at(a.addr, `MHS_OFF_SCFG)) begin
            if (a.prot[`MHS_PROT_NS_BIT]) begin
                res.resp = `MHS_RESP_SLVERR;
            end else begin
                res.data[`MHS_SCFG_EN_BIT] = c.enable;
            end
        end else if (is_at(a.addr, `MHS_OFF_VSTAT)) begin
            res.data[`MHS_VSTAT_SEEN_BIT] = c.seen;
        end else if (is_at(a.addr, `MHS_OFF_PID4)) begin
            res.data[7:4] = `MHS_PID_SIZE_VAL;
            res.data[3:0] = CONT_CODE;
        end else if (is_at(a.addr, `MHS_OFF_PID0)) begin
            res.data[7:0] = PART_NUM[7:0];
        end else if (is_at(a.addr, `MHS_OFF_PID1)) begin
            res.data[7:0] = {DESIGNER[3:0], PART_NUM[11:8]};
        end else if (is_at(a.addr, `MHS_OFF_PID2)) begin
            res.data[7:4] = REVISION;
            res.data[2:0] = DESIGNER[6:4];
            res.data[3] = `MHS_PID_STD_CODE;
        end else if (is_at(a.addr, `MHS_OFF_CID0)) begin
            res.data[7:0] = COMP_ID[7:0];
        end else if (is_at(a.addr, `MHS_OFF_CID1)) begin
            res.data[7:0] = COMP_ID[15:8];
        end else if (is_at(a.addr, `MHS_OFF_CID2)) begin
            res.data[7:0] = COMP_ID[23:16];
        end else if (is_at(a.addr, `MHS_OFF_CID3)) begin
            res.data[7:0] = COMP_ID[31:24];
        end
        read_word = res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    // Write path: holds address and data in either order, then answers.
    always_comb begin
        next_w  = w_q;
        wr_fire = 1'h0;
        wr_viol = 1'h0;
        if (s_axi_awvalid && w_q.awready) begin
            next_w.aw_have = 1'h1;
            next_w.aw      = s_axi_aw;
        end
        if (s_axi_wvalid && w_q.wready) begin
            next_w.w_have = 1'h1;
            next_w.w      = s_axi_w;
        end
        if (w_q.aw_have && w_q.w_have && !w_q.bvalid) begin
            wr_fire = 1'h1;
            wr_viol = w_q.aw.prot[`MHS_PROT_NS_BIT] && is_at(w_q.aw.addr, `MHS_OFF_SCFG);
            next_w.bvalid  = 1'h1;
            next_w.bresp   = wr_viol ? `MHS_RESP_SLVERR : `MHS_RESP_OKAY;
            next_w.aw_have = 1'h0;
            next_w.w_have  = 1'h0;
        end
        if (w_q.bvalid && s_axi_bready) begin
            next_w.bvalid = 1'h0;
        end
        next_w.awready = !next_w.aw_have && !next_w.bvalid;
        next_w.wready  = !next_w.w_have && !next_w.bvalid;
    end

    // Registers the write path.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            w_q <= '0;
        end else begin
            w_q <= next_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Read path: one read at a time, answered in the cycle after acceptance.
    always_comb begin
        next_r  = r_q;
        rd_viol = 1'h0;
        if (r_q.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'h0;
        end
        if (s_axi_arvalid && r_q.arready) begin
            rd_viol = s_axi_ar.prot[`MHS_PROT_NS_BIT] && is_at(s_axi_ar.addr, `MHS_OFF_SCFG);
            next_r.rvalid = 1'h1;
            next_r.r      = read_word(s_axi_ar, c_q);
        end
        next_r.arready = !next_r.rvalid;
    end

    // Registers the read path.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Configuration enable, sticky violation flag and the violation pulse.
    always_comb begin
        next_c = c_q;
        // only bit 0 of the configuration is stored.
        if (wr_fire && !wr_viol && is_at(w_q.aw.addr, `MHS_OFF_SCFG) && w_q.w.strb[0]) begin
            next_c.enable = w_q.w.data[`MHS_SCFG_EN_BIT];
        end
        if (wr_fire && is_at(w_q.aw.addr, `MHS_OFF_VSTAT) && w_q.w.strb[0] &&
            w_q.w.data[`MHS_VSTAT_SEEN_BIT]) begin
            next_c.seen = 1'h0;
        end
        // A violation in the clearing cycle still leaves the flag set.
        if (wr_viol || rd_viol) begin
            next_c.seen = 1'h1;
        end
        // raise status bit 31 only when enabled.
        next_c.pulse = (wr_viol || rd_viol) && c_q.enable;
    end

    // Registers the configuration state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            c_q.enable <= `MHS_RESET_EN;
            c_q.seen   <= 1'h0;
            c_q.pulse  <= 1'h0;
        end else begin
            c_q <= next_c;
        end
    end

    // Outputs taken straight from the state flip-flops.
    assign s_axi_awready        = w_q.awready;
    assign s_axi_wready         = w_q.wready;
    assign s_axi_bvalid         = w_q.bvalid;
    assign s_axi_bresp          = w_q.bresp;
    assign s_axi_arready        = r_q.arready;
    assign s_axi_rvalid         = r_q.rvalid;
    assign s_axi_r              = r_q.r;
    assign violation_set        = c_q.pulse;
    assign violation_irq_enable = c_q.enable;

    ////////////////////////////////////////////////////////////////////////////////

    // Checks on the register answers and the violation link.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // An accepted read of a given register word.
    sequence s_rd(logic [`MHS_ADDR_W-1:0] off);
        s_axi_arvalid && s_axi_arready && is_at(s_axi_ar.addr, off);
    endsequence

    // An accepted non-secure read of the configuration register.
    sequence s_ns_cfg;
        s_rd(`MHS_OFF_SCFG) ##0 s_axi_ar.prot[`MHS_PROT_NS_BIT];
    endsequence

    a_viol_raise:
    assert property (s_ns_cfg ##0 violation_irq_enable |=> violation_set)
        else $error("Violation did not raise the status pulse.");

    a_viol_quiet:
    assert property (!violation_irq_enable |=> !violation_set)
        else $error("Violation pulse while disabled.");

    a_size_zero:
    assert property (s_rd(`MHS_OFF_PID4) |=> s_axi_rvalid && s_axi_r.data[7:4] == `MHS_PID_SIZE_VAL)
        else $error("Size field not zero.");

    a_cont_code:
    assert property (s_rd(`MHS_OFF_PID4) |=> s_axi_r.data[3:0] == CONT_CODE && s_axi_r.data[31:8] == 24'h0)
        else $error("Continuation code wrong.");

    a_pid1_fields:
    assert property (s_rd(`MHS_OFF_PID1) |=> s_axi_r.data == {24'h0, DESIGNER[3:0], PART_NUM[11:8]})
        else $error("Identification one wrong.");

    a_pid2_rev:
    assert property (s_rd(`MHS_OFF_PID2) |=> s_axi_r.data[7:4] == REVISION && s_axi_r.data[2:0] == DESIGNER[6:4])
        else $error("Identification two wrong.");

    a_pid2_std:
    assert property (s_rd(`MHS_OFF_PID2) |=> s_axi_r.data[3] == `MHS_PID_STD_CODE)
        else $error("Standard code flag not one.");

    a_pid0_part:
    assert property (s_rd(`MHS_OFF_PID0) |=> s_axi_r.data == {24'h0, PART_NUM[7:0]})
        else $error("Identification zero wrong.");

    a_comp_byte:
    assert property (s_rd(`MHS_OFF_CID3) |=> s_axi_r.data == {24'h0, COMP_ID[31:24]})
        else $error("Component byte three wrong.");

    a_ns_refuse:
    assert property (s_ns_cfg |=> s_axi_rvalid && s_axi_r.resp == `MHS_RESP_SLVERR && s_axi_r.data == 32'h0)
        else $error("Non-secure configuration read not refused.");

    a_cfg_reserved:
    assert property (s_rd(`MHS_OFF_SCFG) ##0 !s_axi_ar.prot[`MHS_PROT_NS_BIT] |=> s_axi_r.data[31:1] == 31'h0)
        else $error("Reserved configuration bits not zero.");

    a_enable_held:
    assert property (!wr_fire |=> $stable(violation_irq_enable))
        else $error("Enable changed without a write.");

    // A write to the configuration register that is being carried out.
    sequence s_wr_cfg;
        wr_fire && is_at(w_q.aw.addr, `MHS_OFF_SCFG);
    endsequence

    a_ns_wr_refuse:
    assert property (s_wr_cfg ##0 w_q.aw.prot[`MHS_PROT_NS_BIT] |=>
                     s_axi_bvalid && s_axi_bresp == `MHS_RESP_SLVERR && $stable(violation_irq_enable))
        else $error("Non-secure configuration write not refused.");

    a_wr_pulse:
    assert property (s_wr_cfg ##0 w_q.aw.prot[`MHS_PROT_NS_BIT] ##0 violation_irq_enable |=> violation_set)
        else $error("Write violation did not raise the status pulse.");

    a_cfg_store:
    assert property (s_wr_cfg ##0 !w_q.aw.prot[`MHS_PROT_NS_BIT] ##0 w_q.w.strb[0] |=>
                     violation_irq_enable == $past(w_q.w.data[`MHS_SCFG_EN_BIT]))
        else $error("Secure configuration write not stored.");

    a_seen_sticky:
    assert property ((wr_viol || rd_viol) |=> c_q.seen)
        else $error("Violation not recorded in the status flag.");

    a_comp_byte0:
    assert property (s_rd(`MHS_OFF_CID0) |=> s_axi_r.data == {24'h0, COMP_ID[7:0]})
        else $error("Component byte zero wrong.");

    a_comp_byte1:
    assert property (s_rd(`MHS_OFF_CID1) |=> s_axi_r.data == {24'h0, COMP_ID[15:8]})
        else $error("Component byte one wrong.");

    a_comp_byte2:
    assert property (s_rd(`MHS_OFF_CID2) |=> s_axi_r.data == {24'h0, COMP_ID[23:16]})
        else $error("Component byte two wrong.");

    a_pid3_zero:
    assert property (s_rd(`MHS_OFF_PID3) |=> s_axi_r.data == 32'h0)
        else $error("Identification three not zero.");

    a_pid2_upper:
    assert property (s_rd(`MHS_OFF_PID2) |=> s_axi_r.data[31:8] == 24'h0)
        else $error("Identification two upper bits not zero.");

    a_bvalid_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped before it was taken.");

    a_rvalid_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_r))
        else $error("Read answer dropped before it was taken.");

    a_ar_blocked:
    assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read address accepted while an answer stands.");

    a_wr_blocked:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("Write accepted while a response stands.");

endmodule

// ### design/mhs_regs.svh
`ifndef MHS_REGS_SVH
`define MHS_REGS_SVH

////////////////////////////////////////////////////////////////////////////////

// Address width of the 4KB register window.
`define MHS_ADDR_W          12

// Byte offsets of the registers in the window.
`define MHS_OFF_SCFG        12'h400
`define MHS_OFF_VSTAT       12'h408
`define MHS_OFF_PID4        12'hFD0
`define MHS_OFF_PID0        12'hFE0
`define MHS_OFF_PID1        12'hFE4
`define MHS_OFF_PID2        12'hFE8
`define MHS_OFF_PID3        12'hFEC
`define MHS_OFF_CID0        12'hFF0
`define MHS_OFF_CID1        12'hFF4
`define MHS_OFF_CID2        12'hFF8
`define MHS_OFF_CID3        12'hFFC

////////////////////////////////////////////////////////////////////////////////

// Field positions.
`define MHS_SCFG_EN_BIT     0
`define MHS_VSTAT_SEEN_BIT  0
`define MHS_PROT_NS_BIT     1

// Fixed field values.
`define MHS_PID_SIZE_VAL    4'h0
`define MHS_PID_STD_CODE    1'h1
`define MHS_RESET_EN        1'h0

// Bus responses.
`define MHS_RESP_OKAY       2'h0
`define MHS_RESP_SLVERR     2'h2

`endif

// ### testbench/mhs_regs_test.sv
`include "mhs_regs.svh"

module mhs_regs_test
    import mhs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // Identity values, all arbitrary.
    localparam logic [11:0] PART = 12'h3C7;
    localparam logic [6:0]  DES  = 7'h55;
    localparam logic [3:0]  CONT = 4'h9;
    localparam logic [3:0]  REV  = 4'h6;
    localparam logic [31:0] COMP = 32'h9E81B42D;

    logic          clk           = 1'b0;
    logic          rst           = 1'b1;
    logic          s_axi_awvalid = 1'b0;
    logic          s_axi_wvalid  = 1'b0;
    logic          s_axi_bready  = 1'b0;
    logic          s_axi_arvalid = 1'b0;
    logic          s_axi_rready  = 1'b0;
    mhs_addr_type  s_axi_aw      = '0;
    mhs_addr_type  s_axi_ar      = '0;
    mhs_wdata_type s_axi_w       = '0;
    logic          s_axi_awready;
    logic          s_axi_wready;
    logic          s_axi_bvalid;
    logic [1:0]    s_axi_bresp;
    logic          s_axi_arready;
    logic          s_axi_rvalid;
    mhs_rdata_type s_axi_r;
    logic          violation_set;
    logic          violation_irq_enable;
    int            fails         = 0;
    int            num_checks    = 0;
    int            pulses        = 0;
    int            pulses_exp    = 0;
    integer        seed          = 46;
    logic          en            = 1'b0;
    logic          seen          = 1'b0;
    logic [11:0]   addr_tab [13] = '{`MHS_OFF_SCFG, `MHS_OFF_VSTAT, `MHS_OFF_PID4, `MHS_OFF_PID0, `MHS_OFF_PID1,
        `MHS_OFF_PID2, `MHS_OFF_PID3, `MHS_OFF_CID0, `MHS_OFF_CID1, `MHS_OFF_CID2, `MHS_OFF_CID3, 12'h404, 12'h800};

    mhs_regs #(.PART_NUM(PART), .DESIGNER(DES), .CONT_CODE(CONT), .REVISION(REV), .COMP_ID(COMP)) DUT (
        .clk(clk), .rst(rst),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_aw(s_axi_aw),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_w(s_axi_w),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_ar(s_axi_ar),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_r(s_axi_r),
        .violation_set(violation_set), .violation_irq_enable(violation_irq_enable)
    );

    // Clock generator, 50 ns period.
    initial begin
        forever #25 clk = ~clk;
    end

    // Counts cycles in which the status-set pulse is high.
    always @(posedge clk) begin
        if (violation_set === 1'b1) pulses <= pulses + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Expected read data of one address for a secure or non-secure access.
    function automatic logic [31:0] exp_word(input logic [11:0] a, input logic ns);
        case (a)
            `MHS_OFF_SCFG:  exp_word = ns ? 32'h0 : {31'h0, en};
            `MHS_OFF_VSTAT: exp_word = {31'h0, seen};
            `MHS_OFF_PID4:  exp_word = {24'h0, 4'h0, CONT};
            `MHS_OFF_PID0:  exp_word = {24'h0, PART[7:0]};
            `MHS_OFF_PID1:  exp_word = {24'h0, DES[3:0], PART[11:8]};
            `MHS_OFF_PID2:  exp_word = {24'h0, REV, 1'b1, DES[6:4]};
            `MHS_OFF_CID0:  exp_word = {24'h0, COMP[7:0]};
            `MHS_OFF_CID1:  exp_word = {24'h0, COMP[15:8]};
            `MHS_OFF_CID2:  exp_word = {24'h0, COMP[23:16]};
            `MHS_OFF_CID3:  exp_word = {24'h0, COMP[31:24]};
            default:        exp_word = 32'h0;
        endcase
    endfunction

    // Compares a data word.
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Compares a response code.
    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One write; waits for the answer with no limit, so a missing answer hangs the run until the timeout.
    task automatic axi_write(input logic [11:0] a, input logic [2:0] p, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        resp = 2'h3;
        s_axi_awvalid <= 1'b1;
        s_axi_aw <= '{a, p};
        s_axi_wvalid <= 1'b1;
        s_axi_w <= '{d, s};
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) begin
                resp = s_axi_bresp;
                break;
            end
        end
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask

    // One read; the pulse is sampled in the cycle that the data stands.
    task automatic axi_read(input logic [11:0] a, input logic [2:0] p, output logic [31:0] d, output logic [1:0] resp,
                            output logic pulse);
        resp = 2'h3;
        d = 32'h0;
        pulse = 1'b0;
        s_axi_arvalid <= 1'b1;
        s_axi_ar <= '{a, p};
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_r.data;
                resp = s_axi_r.resp;
                pulse = violation_set;
                break;
            end
        end
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask

    // Reads one address and checks data, response and pulse.
    task automatic rd_chk(input logic [11:0] a, input logic ns);
        logic [31:0] d;
        logic [1:0]  r;
        logic        p;
        logic        viol;
        viol = (a == `MHS_OFF_SCFG) && ns;
        axi_read(a, {1'b0, ns, 1'b0}, d, r, p);
        check_word(d, exp_word(a, ns));
        check_resp(r, viol ? `MHS_RESP_SLVERR : `MHS_RESP_OKAY);
        check_word({31'h0, p}, {31'h0, viol && en});
        if (viol) begin
            if (en) pulses_exp++;
            seen = 1'b1;
        end
    endtask

    // Writes one address, updates the model and checks the effects.
    task automatic wr_chk(input logic [11:0] a, input logic ns, input logic [31:0] d, input logic [3:0] s);
        logic [1:0] r;
        logic       viol;
        viol = (a == `MHS_OFF_SCFG) && ns;
        axi_write(a, {1'b0, ns, 1'b0}, d, s, r);
        if (viol) begin
            if (en) pulses_exp++;
            seen = 1'b1;
        end else if (a == `MHS_OFF_SCFG && s[0]) en = d[0];
        else if (a == `MHS_OFF_VSTAT && s[0] && d[0]) seen = 1'b0;
        check_resp(r, viol ? `MHS_RESP_SLVERR : `MHS_RESP_OKAY);
        check_word({31'h0, violation_irq_enable}, {31'h0, en});
        check_word(pulses, pulses_exp);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////

    // Cuts a hung run short.
    initial begin
        repeat (8000) @(posedge clk);
        fails++;
        end_of_test();
    end

    // Main sequence of directed and random tests.
    initial begin
        int idx;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check_word({31'h0, violation_irq_enable}, 32'h0);
        for (int i = 0; i < 13; i++) rd_chk(addr_tab[i], 1'b0);
        $display("test reset_values done");
        for (int i = 2; i < 13; i++) wr_chk(addr_tab[i], 1'b0, 32'hFFFFFFFF, 4'hF);
        for (int i = 2; i < 13; i++) rd_chk(addr_tab[i], 1'b1);
        $display("test id_write_ignored done");
        wr_chk(`MHS_OFF_SCFG, 1'b0, 32'hFFFFFFFF, 4'hF);
        rd_chk(`MHS_OFF_SCFG, 1'b0);
        rd_chk(`MHS_OFF_SCFG, 1'b1);
        wr_chk(`MHS_OFF_SCFG, 1'b1, 32'h0, 4'hF);
        rd_chk(`MHS_OFF_SCFG, 1'b0);
        rd_chk(`MHS_OFF_VSTAT, 1'b1);
        wr_chk(`MHS_OFF_VSTAT, 1'b1, 32'h1, 4'h1);
        rd_chk(`MHS_OFF_VSTAT, 1'b0);
        $display("test violation_enabled done");
        wr_chk(`MHS_OFF_SCFG, 1'b0, 32'h0, 4'hF);
        rd_chk(`MHS_OFF_SCFG, 1'b1);
        wr_chk(`MHS_OFF_SCFG, 1'b1, 32'hFFFFFFFF, 4'hF);
        wr_chk(`MHS_OFF_SCFG, 1'b0, 32'h1, 4'hE);
        $display("test violation_disabled done");
        for (int i = 0; i < 80; i++) begin
            idx = {$random(seed)} % 13;
            if ($random(seed) & 1) rd_chk(addr_tab[idx], $random(seed));
            else wr_chk(addr_tab[idx], $random(seed), $random(seed), $random(seed));
        end
        $display("test random_access done");
        end_of_test();
    end
endmodule
